// >>> design/bisw_write_seq.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Repeat ordinary writes until whole operand written
// - First clock: address, controls, size, start asserted
// - Second clock: start off, mode=supervisor, data out
// - Sample acknowledge end of third clock, else wait
// - Acknowledge by second clock appears by third
// - Next transfer advances address and operand portion
// - Data drivers released after final acknowledge edge
// - Tied acknowledge gives zero wait states
// - Misaligned operands flagged, never faulted
// - Odd-address instruction fetch raises address error
// - Misaligned noncacheable split into aligned accesses
// - Long at offset one: byte, word, byte
// - Straddling word goes as two byte cycles
// - Inhibited mode when burst off, operand wider
// - Size field never line, reports piece size

// Request buffer, flip-flop storage with registered ready
module bisw_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          not_full_reg;
  logic          push;
  logic          pop;

  // Handshakes on both sides
  assign push      = in_valid && not_full_reg;
  assign pop       = out_valid && out_ready;
  assign in_ready  = not_full_reg;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at depth, which need not be a power of two
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // Fill level; ready is a flop so the upstream sees no comb path
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_reg    <= '0;
      not_full_reg <= 1'b1;
    end else begin
      if (push && !pop) begin
        count_reg    <= count_reg + 1'b1;
        not_full_reg <= (count_reg != (AW+1)'(D - 1));
      end else if (pop && !push) begin
        count_reg    <= count_reg - 1'b1;
        not_full_reg <= 1'b1;
      end
    end
  end
endmodule

// Burst-inhibited asynchronously terminated write sequencer
module bisw_write_seq #(
  parameter int DEPTH = bisw_pkg::FIFO_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [27:0] req_addr,
  input  wire logic [1:0]  req_size,
  input  wire logic [1:0]  req_type,
  input  wire logic        req_super,
  input  wire logic        req_code,
  input  wire logic        req_cacheable,
  input  wire logic        req_burst_en,
  input  wire logic [1:0]  req_port,
  input  wire logic [127:0] req_data,
  input  wire logic        fetch_valid,
  input  wire logic        fetch_addr0,
  input  wire logic        bus_grant_n,
  input  wire logic        async_xfer_ack_n,
  input  wire logic        sync_xfer_ack_n,
  output logic             transfer_start_n,
  output logic [27:0]      bus_addr,
  output logic [1:0]       transfer_type,
  output logic             access_type_mode,
  output logic             bus_rnw,
  output logic [1:0]       transfer_size,
  output logic [31:0]      bus_data_out,
  output logic             bus_data_oe,
  output logic             xfer_done,
  output logic             addr_error,
  output logic             misaligned,
  output logic             burst_inhibit,
  output logic             busy
);
  // Operand bytes from size code
  function automatic logic [4:0] op_bytes(input logic [1:0] sz);
    case (sz)
      bisw_pkg::SIZ_BYTE: op_bytes = 5'h01;
      bisw_pkg::SIZ_WORD: op_bytes = 5'h02;
      bisw_pkg::SIZ_LONG: op_bytes = 5'h04;
      default:            op_bytes = 5'h10;
    endcase
  endfunction

  // Largest aligned piece that fits the port and the bytes left
  function automatic logic [2:0] chunk_len(input logic [1:0] a,
                                           input logic [4:0] rem,
                                           input logic [1:0] port);
    if (port == bisw_pkg::PORT_32 && a == 2'h0 && rem >= 5'h04) begin
      chunk_len = 3'h4;
    end else if (port != bisw_pkg::PORT_8 && !a[0] && rem >= 5'h02) begin
      chunk_len = 3'h2;
    end else begin
      chunk_len = 3'h1;
    end
  endfunction

  // Size field for a piece; line never appears
  function automatic logic [1:0] siz_of(input logic [2:0] n);
    case (n)
      3'h4:    siz_of = bisw_pkg::SIZ_LONG;
      3'h2:    siz_of = bisw_pkg::SIZ_WORD;
      default: siz_of = bisw_pkg::SIZ_BYTE;
    endcase
  endfunction

  // Steer operand bytes onto the lanes of the port, big-endian
  function automatic logic [31:0] lane_data(input logic [127:0] d,
                                            input logic [4:0]   ob,
                                            input logic [4:0]   idx,
                                            input logic [2:0]   n,
                                            input logic [1:0]   a,
                                            input logic [1:0]   port);
    logic [31:0]  w;
    logic [127:0] sh;
    int           lane0;
    int           k;
    w = '0;
    sh = '0;
    k = 0;
    if (port == bisw_pkg::PORT_32) begin
      lane0 = int'(a);
    end else if (port == bisw_pkg::PORT_16) begin
      lane0 = int'(a[0]);
    end else begin
      lane0 = 0;
    end
    for (int j = 0; j < 4; j++) begin
      if (j < int'(n)) begin
        k = int'(ob) - 1 - int'(idx) - j;
        sh = d >> (8 * k);
        w[31 - 8 * (lane0 + j) -: 8] = sh[7:0];
      end
    end
    return w;
  endfunction

  bisw_pkg::bisw_state_t state_reg;
  logic [bisw_pkg::REQ_W-1:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  logic [27:0] cur_addr_reg;
  logic [4:0]  rem_reg;
  logic [4:0]  idx_reg;
  logic [4:0]  ob_reg;
  logic [2:0]  chunk_reg;
  logic [127:0] data_reg;
  logic [1:0]  port_reg;
  logic        super_reg;
  logic        code_reg;
  logic        ack_int_reg;
  logic [27:0] f_addr;
  logic [1:0]  f_size;
  logic [1:0]  f_type;
  logic        f_super;
  logic        f_code;
  logic        f_cache;
  logic        f_burst;
  logic [1:0]  f_port;
  logic [127:0] f_data;
  logic [4:0]  f_bytes;
  logic [2:0]  f_chunk;
  logic        start;
  logic        piece_done;
  logic        last;
  logic [27:0] addr_next;
  logic [4:0]  rem_next;
  logic [2:0]  chunk_next;

  bisw_fifo #(
    .W (bisw_pkg::REQ_W),
    .D (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_addr, req_size, req_type, req_super, req_code,
                 req_cacheable, req_burst_en, req_port, req_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // Unpack head request; cacheable operands are split the same way
  assign {f_addr, f_size, f_type, f_super, f_code, f_cache, f_burst,
          f_port, f_data} = fifo_data;
  assign f_bytes = op_bytes(f_size);
  assign f_chunk = chunk_len(f_addr[1:0], f_bytes, f_port);

  // Only pull work while idle and owning the bus
  assign fifo_ready = (state_reg == bisw_pkg::ST_IDLE) && !bus_grant_n;
  assign start      = fifo_ready && fifo_valid;

  // Sync ack or an early async ack ends C2; async ack ends C3 or a wait
  assign piece_done = (state_reg == bisw_pkg::ST_C2 &&
                       (!sync_xfer_ack_n || ack_int_reg)) ||
                      (state_reg == bisw_pkg::ST_C3 && ack_int_reg);
  assign rem_next   = rem_reg - 5'(chunk_reg);
  assign last       = (rem_next == 5'h00);
  assign addr_next  = cur_addr_reg + 28'(chunk_reg);
  assign chunk_next = chunk_len(addr_next[1:0], rem_next, port_reg);

  // Registered acknowledge: a level seen at C2 is sampled at end of C3
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ack_int_reg <= 1'b0;
    end else begin
      ack_int_reg <= !async_xfer_ack_n;
    end
  end

  // Per-transfer clock sequence
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= bisw_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        bisw_pkg::ST_IDLE: begin
          if (start) begin
            state_reg <= bisw_pkg::ST_C1;
          end
        end
        bisw_pkg::ST_C1: begin
          state_reg <= bisw_pkg::ST_C2;
        end
        bisw_pkg::ST_C2, bisw_pkg::ST_C3: begin
          if (piece_done) begin
            state_reg <= last ? bisw_pkg::ST_IDLE : bisw_pkg::ST_C1;
          end else begin
            state_reg <= bisw_pkg::ST_C3;
          end
        end
        default: begin
          state_reg <= bisw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Operand progress
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur_addr_reg <= '0;
      rem_reg      <= '0;
      idx_reg      <= '0;
      ob_reg       <= '0;
      chunk_reg    <= '0;
      data_reg     <= '0;
      port_reg     <= bisw_pkg::PORT_32;
      super_reg    <= 1'b0;
      code_reg     <= bisw_pkg::ATM_DATA;
    end else if (start) begin
      cur_addr_reg <= f_addr;
      rem_reg      <= f_bytes;
      idx_reg      <= '0;
      ob_reg       <= f_bytes;
      chunk_reg    <= f_chunk;
      data_reg     <= f_data;
      port_reg     <= f_port;
      super_reg    <= f_super;
      code_reg     <= f_code ? bisw_pkg::ATM_CODE : bisw_pkg::ATM_DATA;
    end else if (piece_done && !last) begin
      cur_addr_reg <= addr_next;
      rem_reg      <= rem_next;
      idx_reg      <= idx_reg + 5'(chunk_reg);
      chunk_reg    <= chunk_next;
    end
  end

  // Address and control pins, updated on entry to C1 and C2
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      transfer_start_n <= 1'b1;
      bus_addr         <= '0;
      transfer_type    <= '0;
      access_type_mode <= bisw_pkg::ATM_DATA;
      bus_rnw          <= 1'b1;
      transfer_size    <= bisw_pkg::SIZ_BYTE;
    end else if (start) begin
      transfer_start_n <= 1'b0;
      bus_addr         <= f_addr;
      transfer_type    <= f_type;
      access_type_mode <= f_code ? bisw_pkg::ATM_CODE : bisw_pkg::ATM_DATA;
      bus_rnw          <= bisw_pkg::RNW_WRITE;
      transfer_size    <= siz_of(f_chunk);
    end else if (piece_done && !last) begin
      transfer_start_n <= 1'b0;
      bus_addr         <= addr_next;
      access_type_mode <= code_reg;
      transfer_size    <= siz_of(chunk_next);
    end else if (state_reg == bisw_pkg::ST_C1) begin
      transfer_start_n <= 1'b1;
      access_type_mode <= super_reg;
    end
  end

  // Data bus; drivers drop on the edge that recognises the last ack
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bus_data_out <= '0;
      bus_data_oe  <= 1'b0;
    end else if (state_reg == bisw_pkg::ST_C1) begin
      bus_data_out <= lane_data(data_reg, ob_reg, idx_reg, chunk_reg,
                                cur_addr_reg[1:0], port_reg);
      bus_data_oe  <= 1'b1;
    end else if (piece_done && last) begin
      bus_data_oe  <= 1'b0;
    end
  end

  // Status: mode and alignment of the operand in flight
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      misaligned    <= 1'b0;
      burst_inhibit <= 1'b0;
    end else if (start) begin
      misaligned    <= (f_size == bisw_pkg::SIZ_WORD && f_addr[0]) ||
                       (f_bytes >= 5'h04 && f_addr[1:0] != 2'h0);
      burst_inhibit <= !f_burst &&
                       (f_bytes > {2'h0, chunk_len(2'h0, 5'h10, f_port)});
    end
  end

  // Event pulses and busy level; odd fetch is reported, never put on the bus
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      xfer_done  <= 1'b0;
      addr_error <= 1'b0;
      busy       <= 1'b0;
    end else begin
      xfer_done  <= piece_done && last;
      addr_error <= fetch_valid && fetch_addr0;
      busy       <= start || (busy && !(piece_done && last));
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_ts_one;
    !transfer_start_n |=> transfer_start_n && bus_data_oe;
  endproperty
  a_ts_one: assert property (p_ts_one)
    else $error("transfer start held more than one clock");

  property p_c1_write;
    !transfer_start_n |-> bus_rnw == bisw_pkg::RNW_WRITE &&
                          transfer_size != bisw_pkg::SIZ_LINE;
  endproperty
  a_c1_write: assert property (p_c1_write)
    else $error("bad direction or line size in first clock");

  property p_c2_mode;
    state_reg == bisw_pkg::ST_C2 |-> access_type_mode == super_reg;
  endproperty
  a_c2_mode: assert property (p_c2_mode)
    else $error("mode line not supervisor level in second clock");

  property p_wait;
    state_reg == bisw_pkg::ST_C3 && !ack_int_reg
      |=> state_reg == bisw_pkg::ST_C3 && transfer_start_n;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait state not inserted");

  property p_release;
    piece_done && last |=> !bus_data_oe ##1 !bus_data_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("data bus not released after final ack");

  property p_advance;
    piece_done && !last
      |=> !transfer_start_n && bus_addr == $past(addr_next);
  endproperty
  a_advance: assert property (p_advance)
    else $error("next transfer address not advanced");

  property p_odd_fetch;
    fetch_valid && fetch_addr0 |=> addr_error;
  endproperty
  a_odd_fetch: assert property (p_odd_fetch)
    else $error("odd fetch without address error");

  property p_aligned;
    !transfer_start_n |->
      (transfer_size != bisw_pkg::SIZ_LONG || bus_addr[1:0] == 2'h0) &&
      (transfer_size != bisw_pkg::SIZ_WORD || !bus_addr[0]);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("bus cycle not naturally aligned");

  property p_zero_wait;
    state_reg == bisw_pkg::ST_C1 && !async_xfer_ack_n
      |=> state_reg == bisw_pkg::ST_C2 ##1 state_reg != bisw_pkg::ST_C3;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("tied acknowledge still gave a wait state");

  property p_ack_seen;
    state_reg == bisw_pkg::ST_C2 && !async_xfer_ack_n
      |-> ##[0:1] piece_done;
  endproperty
  a_ack_seen: assert property (p_ack_seen)
    else $error("acknowledge in second clock missed at third");

  c_zero_wait: cover property (state_reg == bisw_pkg::ST_C2 && piece_done);
  c_wait: cover property (state_reg == bisw_pkg::ST_C3 && !ack_int_reg);
  c_three_piece: cover property (start && f_bytes == 5'h04 &&
                                 f_addr[1:0] == 2'h1);
  c_line: cover property (xfer_done && burst_inhibit);
endmodule

// >>> design/bisw_pkg.sv
package bisw_pkg;

  // Bus widths and request buffer depth
  localparam int ADDR_W     = 28;
  localparam int DATA_W     = 32;
  localparam int OPD_W      = 128;
  localparam int FIFO_DEPTH = 8;

  // Transfer size field codes
  localparam logic [1:0] SIZ_LONG = 2'h0;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  localparam logic [1:0] SIZ_WORD = 2'h2;
  localparam logic [1:0] SIZ_LINE = 2'h3;

  // Port width codes of the addressed region
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_8  = 2'h1;
  localparam logic [1:0] PORT_16 = 2'h2;

  // Access type/mode levels and direction
  localparam logic ATM_CODE  = 1'b1;
  localparam logic ATM_DATA  = 1'b0;
  localparam logic RNW_WRITE = 1'b0;

  // Request word: addr, size, type, super, code, cacheable, burst, port, data
  localparam int REQ_W = ADDR_W + 2 + 2 + 1 + 1 + 1 + 1 + 2 + OPD_W;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_C1   = 4'h2,
    ST_C2   = 4'h4,
    ST_C3   = 4'h8
  } bisw_state_t;

endpackage

// >>> verif/bisw_slave_model.sv
`timescale 1ns/1ps
// Far-side memory model: logs every transfer and acknowledges it
module bisw_slave_model (
  input  wire logic        sys_clk,
  input  wire logic        transfer_start_n,
  input  wire logic [27:0] bus_addr,
  input  wire logic [1:0]  transfer_type,
  input  wire logic        access_type_mode,
  input  wire logic        bus_rnw,
  input  wire logic [1:0]  transfer_size,
  input  wire logic [31:0] bus_data_out,
  input  wire logic        bus_data_oe,
  input  wire logic [1:0]  ack_mode,
  input  wire logic [3:0]  ack_wait,
  output logic             async_xfer_ack_n,
  output logic             sync_xfer_ack_n
);
  logic [27:0] q_addr[$];
  logic [1:0]  q_size[$];
  logic [3:0]  q_c1[$];
  logic [2:0]  q_c2[$];
  logic [31:0] q_data[$];
  int          q_cyc[$];
  int          cyc = 0;
  logic        ack_reg;

  // Mode 2 ties the async acknowledge low, as a single-wire tie-off
  assign async_xfer_ack_n = (ack_mode == 2'h2) ? 1'b0 : ack_reg;

  // Free-running count, used to judge spacing of transfer starts
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  // Log C1 and C2 values; modes: 0 async with waits, 1 sync, 2 tied
  initial begin
    ack_reg = 1'b1;
    sync_xfer_ack_n = 1'b1;
    forever begin
      @(posedge sys_clk);
      if (transfer_start_n === 1'b0) begin
        q_addr.push_back(bus_addr);
        q_size.push_back(transfer_size);
        q_c1.push_back({bus_rnw, access_type_mode, transfer_type});
        q_cyc.push_back(cyc);
        #1;
        // Acknowledge only once ready to take the data
        if (ack_mode == 2'h1) begin
          sync_xfer_ack_n = 1'b0;
        end else if (ack_mode == 2'h0 && ack_wait == 4'h0) begin
          ack_reg = 1'b0;
        end
        @(posedge sys_clk);
        q_data.push_back(bus_data_out);
        q_c2.push_back({transfer_start_n, bus_data_oe, access_type_mode});
        #1;
        // Never left low: another master may drive that line
        sync_xfer_ack_n = 1'b1;
        if (ack_mode == 2'h0 && ack_wait != 4'h0) begin
          repeat (ack_wait - 4'h1) begin
            @(posedge sys_clk);
            #1;
          end
          ack_reg = 1'b0;
          @(posedge sys_clk);
          #1;
        end
        ack_reg = 1'b1;
      end
    end
  end
endmodule

// >>> verif/test_burst_inhibited_async_write_bus.sv
`timescale 1ns/1ps
module test_burst_inhibited_async_write_bus;
  logic         sys_clk, rstn, req_valid, req_ready;
  logic [27:0]  req_addr, bus_addr;
  logic [1:0]   req_size, req_type, req_port, ack_mode;
  logic         req_super, req_code, req_cacheable, req_burst_en;
  logic [127:0] req_data;
  logic         fetch_valid, fetch_addr0, bus_grant_n;
  logic         async_xfer_ack_n, sync_xfer_ack_n, transfer_start_n;
  logic [1:0]   transfer_type, transfer_size;
  logic         access_type_mode, bus_rnw, bus_data_oe;
  logic [31:0]  bus_data_out;
  logic         xfer_done, addr_error, misaligned, burst_inhibit, busy;
  logic [3:0]   ack_wait;
  int           fails, comparisons, base, spc;

  bisw_write_seq i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_size(req_size),
    .req_type(req_type), .req_super(req_super), .req_code(req_code),
    .req_cacheable(req_cacheable), .req_burst_en(req_burst_en),
    .req_port(req_port), .req_data(req_data), .fetch_valid(fetch_valid),
    .fetch_addr0(fetch_addr0), .bus_grant_n(bus_grant_n),
    .async_xfer_ack_n(async_xfer_ack_n), .sync_xfer_ack_n(sync_xfer_ack_n),
    .transfer_start_n(transfer_start_n), .bus_addr(bus_addr),
    .transfer_type(transfer_type), .access_type_mode(access_type_mode),
    .bus_rnw(bus_rnw), .transfer_size(transfer_size),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .xfer_done(xfer_done), .addr_error(addr_error),
    .misaligned(misaligned), .burst_inhibit(burst_inhibit), .busy(busy)
  );

  bisw_slave_model i_slave (
    .sys_clk(sys_clk), .transfer_start_n(transfer_start_n),
    .bus_addr(bus_addr), .transfer_type(transfer_type),
    .access_type_mode(access_type_mode), .bus_rnw(bus_rnw),
    .transfer_size(transfer_size), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .ack_mode(ack_mode), .ack_wait(ack_wait),
    .async_xfer_ack_n(async_xfer_ack_n), .sync_xfer_ack_n(sync_xfer_ack_n)
  );

  // Clock, 4 ns period
  always #2 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expd);
    comparisons++;
    if (seen !== expd) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, expd, seen);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Offer one operand and hold it until the buffer takes it
  task automatic push(input logic [27:0] a, input logic [1:0] s,
                      input logic [1:0] p, input logic [127:0] d);
    int n;
    req_addr = a;
    req_size = s;
    req_port = p;
    req_data = d;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
  endtask

  // Bounded wait for completion pulses; data must be off by then
  task automatic wait_done(input int cnt);
    int n;
    int got;
    n = 0;
    got = 0;
    while (got < cnt && n < 500 * cnt) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (xfer_done === 1'b1) begin
        got++;
        check("oe busy at done", {30'h0, busy, bus_data_oe}, 32'h0);
      end
    end
    check("done pulses", got, cnt);
  endtask

  task automatic run_op(input logic [27:0] a, input logic [1:0] s,
                        input logic [1:0] p, input logic [127:0] d,
                        input logic [1:0] m, input logic [3:0] w,
                        input int np, input int sp);
    ack_mode = m;
    ack_wait = w;
    spc = sp;
    base = i_slave.q_addr.size();
    push(a, s, p, d);
    wait_done(1);
    check("piece count", i_slave.q_addr.size() - base, np);
  endtask

  // Judge one logged bus piece against its expected values
  task automatic piece(input int k, input logic [27:0] a,
                       input logic [1:0] s, input logic [31:0] d,
                       input logic [31:0] m);
    int i;
    i = base + k;
    check("address", {4'h0, i_slave.q_addr[i]}, {4'h0, a});
    check("size", {30'h0, i_slave.q_size[i]}, {30'h0, s});
    check("data", i_slave.q_data[i] & m, d);
    check("c1 controls", {28'h0, i_slave.q_c1[i]},
          {28'h0, bisw_pkg::RNW_WRITE, req_code, req_type});
    check("c2 controls", {29'h0, i_slave.q_c2[i]},
          {29'h0, 2'h3, req_super});
    if (k > 0 && spc != 0) begin
      check("start spacing", i_slave.q_cyc[i] - i_slave.q_cyc[i - 1],
            spc);
    end
  endtask

  task automatic t_reset;
    check("start idle", {31'h0, transfer_start_n}, 32'h1);
    check("rnw reset", {31'h0, bus_rnw}, 32'h1);
    check("size reset", {30'h0, transfer_size}, 32'h1);
    check("oe reset", {31'h0, bus_data_oe}, 32'h0);
    check("ready reset", {31'h0, req_ready}, 32'h1);
  endtask

  // Aligned long on a 32-bit port, one async wait
  task automatic t_long32;
    req_type = 2'h1;
    req_super = 1'b0;
    req_code = 1'b0;
    req_burst_en = 1'b1;
    run_op(28'h100, bisw_pkg::SIZ_LONG, bisw_pkg::PORT_32,
           {96'h0, 32'ha1b2c3d4}, 2'h0, 4'h1, 1, 4);
    piece(0, 28'h100, bisw_pkg::SIZ_LONG, 32'ha1b2c3d4, 32'hffffffff);
    check("inhibit", {31'h0, burst_inhibit}, 32'h0);
    check("aligned", {31'h0, misaligned}, 32'h0);
  endtask

  // Long to a 16-bit port: two words on the upper lanes
  task automatic t_long16;
    req_type = 2'h2;
    req_super = 1'b1;
    req_burst_en = 1'b0;
    run_op(28'h200, bisw_pkg::SIZ_LONG, bisw_pkg::PORT_16,
           {96'h0, 32'ha1b2c3d4}, 2'h0, 4'h1, 2, 4);
    piece(0, 28'h200, bisw_pkg::SIZ_WORD, 32'ha1b20000, 32'hffff0000);
    piece(1, 28'h202, bisw_pkg::SIZ_WORD, 32'hc3d40000, 32'hffff0000);
    check("inhibit", {31'h0, burst_inhibit}, 32'h1);
  endtask

  // Long at offset one: byte, word, byte
  task automatic t_mis_long;
    req_type = 2'h0;
    req_super = 1'b0;
    req_code = 1'b1;
    run_op(28'h301, bisw_pkg::SIZ_LONG, bisw_pkg::PORT_32,
           {96'h0, 32'ha1b2c3d4}, 2'h0, 4'h0, 3, 3);
    piece(0, 28'h301, bisw_pkg::SIZ_BYTE, 32'h00a10000, 32'h00ff0000);
    piece(1, 28'h302, bisw_pkg::SIZ_WORD, 32'h0000b2c3, 32'h0000ffff);
    piece(2, 28'h304, bisw_pkg::SIZ_BYTE, 32'hd4000000, 32'hff000000);
    check("misaligned", {31'h0, misaligned}, 32'h1);
  endtask

  // Straddling word with the async acknowledge tied low
  task automatic t_mis_word;
    run_op(28'h403, bisw_pkg::SIZ_WORD, bisw_pkg::PORT_32,
           {112'h0, 16'ha1b2}, 2'h2, 4'h0, 2, 2);
    piece(0, 28'h403, bisw_pkg::SIZ_BYTE, 32'h000000a1, 32'h000000ff);
    piece(1, 28'h404, bisw_pkg::SIZ_BYTE, 32'hb2000000, 32'hff000000);
    check("tied spacing", i_slave.q_cyc[base + 1] - i_slave.q_cyc[base],
          2);
  endtask

  // Line on a 32-bit port with sync acknowledge: four longs
  task automatic t_line32;
    logic [127:0] d;
    d = 128'h00112233_44556677_8899aabb_ccddeeff;
    req_type = 2'h3;
    req_super = 1'b1;
    req_code = 1'b0;
    run_op(28'h500, bisw_pkg::SIZ_LINE, bisw_pkg::PORT_32, d,
           2'h1, 4'h0, 4, 2);
    for (int k = 0; k < 4; k++) begin
      piece(k, 28'h500 + 28'(4 * k), bisw_pkg::SIZ_LONG,
            d[127 - 32 * k -: 32], 32'hffffffff);
    end
    check("inhibit", {31'h0, burst_inhibit}, 32'h1);
  endtask

  // Long to an 8-bit port with two async waits per byte
  task automatic t_long8;
    logic [31:0] d;
    d = 32'h5a6b7c8d;
    run_op(28'h600, bisw_pkg::SIZ_LONG, bisw_pkg::PORT_8,
           {96'h0, d}, 2'h0, 4'h2, 4, 5);
    for (int k = 0; k < 4; k++) begin
      piece(k, 28'h600 + 28'(k), bisw_pkg::SIZ_BYTE,
            {d[31 - 8 * k -: 8], 24'h0}, 32'hff000000);
    end
  endtask

  // Even fetch is quiet, odd fetch gives a one-cycle error pulse
  task automatic t_fetch;
    fetch_addr0 = 1'b0;
    fetch_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    fetch_addr0 = 1'b1;
    check("even fetch", {31'h0, addr_error}, 32'h0);
    @(posedge sys_clk);
    #1;
    fetch_valid = 1'b0;
    check("odd fetch", {31'h0, addr_error}, 32'h1);
    @(posedge sys_clk);
    #1;
    check("error pulse", {31'h0, addr_error}, 32'h0);
  endtask

  // Fill the buffer with the bus withheld, then drain it in order
  task automatic t_fifo;
    bus_grant_n = 1'b1;
    ack_mode = 2'h2;
    spc = 0;
    base = i_slave.q_addr.size();
    for (int i = 0; i < 8; i++) begin
      push(28'h700 + 28'(4 * i), bisw_pkg::SIZ_LONG, bisw_pkg::PORT_32,
           128'(i));
      @(posedge sys_clk);
      #1;
    end
    check("full refuses", {31'h0, req_ready}, 32'h0);
    check("no start", {31'h0, transfer_start_n}, 32'h1);
    bus_grant_n = 1'b0;
    @(posedge sys_clk);
    #1;
    check("busy", {31'h0, busy}, 32'h1);
    wait_done(8);
    for (int i = 0; i < 8; i++) begin
      piece(i, 28'h700 + 28'(4 * i), bisw_pkg::SIZ_LONG, 32'(i),
            32'hffffffff);
    end
    check("drained", {31'h0, req_ready}, 32'h1);
  endtask

  // Watchdog, far beyond the roughly 130 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("[ERR] watchdog expected finish seen timeout");
    stop_test();
  end

  // Main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    sys_clk = 1'b0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_addr = 28'h0;
    req_size = 2'h0;
    req_type = 2'h0;
    req_port = 2'h0;
    req_super = 1'b0;
    req_code = 1'b0;
    req_cacheable = 1'b0;
    req_burst_en = 1'b0;
    req_data = 128'h0;
    fetch_valid = 1'b0;
    fetch_addr0 = 1'b0;
    bus_grant_n = 1'b0;
    ack_mode = 2'h0;
    ack_wait = 4'h0;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_long32();
    t_long16();
    t_mis_long();
    t_mis_word();
    t_line32();
    t_long8();
    t_fetch();
    t_fifo();
    stop_test();
  end
endmodule
